// ===== dma_channel_control.sv
// DMA channel control: request selection, arming, counts, arbitration, halts.
// Assumes an APB master on core_clk and asynchronous external request pins.
//
// Notes on behaviour
// - Internal select ignores the external pin
// - External select ignores internal sources
// - Internal source chosen per module
// - Arm bit writes take effect only with guard set
// - Requests seen only while armed
// - Sync codes: 00 none, 01 source
// - Unsynchronized channel runs once armed
// - 16-bit counter decrements every transfer
// - Stop-at-zero bit disarms at zero
// - Unsynchronized always stops at zero
// - Interrupt needs stop bit and enable
// - In-module priority, equal ones rotate
// - Module priority, equal ones rotate
// - Serial request pulse moves one byte
// - Halt flag set by hardware NMI
// - Module halt bits suspend each module
// - Halt writes gated by mask bits
// - External pins pass a two-stage synchronizer
// - At least four cycles request to transfer
// - Eight cycles per transfer, plus two for destination sync
// - Code 10 selects destination sync
// - Size bit picks word or byte
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire dma_ctl_pkg::apb_req_type apb_req,
	output dma_ctl_pkg::apb_rsp_type apb_rsp,
	input wire logic [3:0] external_request_pin,
	input wire logic timer_request,
	input wire logic [1:0] serial_request,
	input wire logic hw_nmi,
	input wire logic irq_return,
	output logic [3:0] tc_irq,
	output dma_ctl_pkg::xfer_out_type xfer
);
	import dma_ctl_pkg::*;

	typedef struct packed {
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] ireq_prev;
		logic [3:0] pending;
		chan_cfg_type [3:0] cfg;
		logic [3:0][15:0] transfer_counter;
		logic module_a_priority;
		logic module_b_priority;
		logic module_a_internal_source;
		logic module_b_internal_source;
		logic halt_on_nmi_flag;
		logic halt_module_a;
		logic halt_module_b;
		logic [1:0] rot_in;
		logic rot_mod;
		xfer_state_type st;
		logic [3:0] cnt;
		logic [1:0] cur;
		logic [3:0] tc_irq;
		xfer_out_type xfer;
		apb_rsp_type rsp;
	} state_type;

	state_type s_q;
	state_type s_d;

	logic wr;
	logic rd;
	logic [3:0] reqsrc;
	logic [3:0] eligible;
	logic [1:0] mod_win;
	logic [1:0] mod_pick;
	logic [1:0] grant;
	logic any_grant;
	logic [1:0] winner_mod;
	logic [3:0] run_len;

	assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

	// Per-channel request source and eligibility
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			logic internal_src;
			logic int_req;
			logic halted;
			// Module A holds channels 0,1; module B channels 2,3
			assign internal_src = (g < 2) ? s_q.module_a_internal_source
				: s_q.module_b_internal_source;
			assign int_req = internal_src ? serial_request[g / 2] : timer_request;
			assign reqsrc[g] = s_q.cfg[g].internal_request_select ? int_req
				: s_q.sync2[g];
			assign halted = s_q.halt_on_nmi_flag
				|| ((g < 2) ? s_q.halt_module_a : s_q.halt_module_b);
			// Unsynchronized channels need no request once armed
			assign eligible[g] = s_q.cfg[g].channel_arm && !halted
				&& ((s_q.cfg[g].sync_mode_field == SYNC_NONE) || s_q.pending[g]);
		end
	endgenerate

	// In-module arbitration per module
	always_comb begin
		for (int m = 0; m < 2; m++) begin
			logic e0;
			logic e1;
			logic p0;
			logic p1;
			e0 = eligible[2 * m];
			e1 = eligible[2 * m + 1];
			p0 = s_q.cfg[2 * m].high_prio;
			p1 = s_q.cfg[2 * m + 1].high_prio;
			mod_win[m] = e0 || e1;
			if (e0 && e1) begin
				if (p0 != p1) begin
					mod_pick[m] = p1;
				end else begin
					mod_pick[m] = s_q.rot_in[m];
				end
			end else begin
				mod_pick[m] = e1;
			end
		end
	end

	// Module arbitration
	always_comb begin
		any_grant = mod_win[0] || mod_win[1];
		if (mod_win[0] && mod_win[1]) begin
			if (s_q.module_a_priority != s_q.module_b_priority) begin
				winner_mod = {1'b0, s_q.module_b_priority};
			end else begin
				winner_mod = {1'b0, s_q.rot_mod};
			end
		end else begin
			winner_mod = {1'b0, mod_win[1]};
		end
		grant = {winner_mod[0], mod_pick[winner_mod[0]]};
	end

	// Bus occupancy: eight cycles, two more for destination sync
	always_comb begin
		if (s_q.cfg[s_q.cur].sync_mode_field == SYNC_DST) begin
			run_len = 4'(XFER_CYCLES + DEST_IDLE_CYCLES - 1);
		end else begin
			run_len = 4'(XFER_CYCLES - 1);
		end
	end

	// Next-state logic
	always_comb begin
		logic [7:0] a;
		logic [31:0] wd;
		logic [1:0] ch;
		logic [15:0] nc;
		logic [3:0] new_req;
		a = apb_req.paddr;
		wd = apb_req.pwdata;
		ch = 2'(a[4:3]);
		nc = 16'h0000;
		new_req = 4'h0;
		s_d = s_q;
		s_d.tc_irq = 4'h0;
		s_d.xfer.done = 1'b0;
		// Two-stage pin synchronizer
		s_d.sync1 = external_request_pin;
		s_d.sync2 = s_q.sync1;
		// Rising edges of the selected source latch a pending request
		s_d.ireq_prev = reqsrc;
		for (int i = 0; i < NUM_CH; i++) begin
			if (reqsrc[i] && !s_q.ireq_prev[i] && s_q.cfg[i].channel_arm) begin
				new_req[i] = 1'b1;
			end
		end
		// NMI halt flag; hardware set wins over clear
		if (irq_return) begin
			s_d.halt_on_nmi_flag = 1'b0;
		end
		// Register writes
		if (wr) begin
			if (a < PRIO_OFS && a[2:0] == CTRL_OFS[2:0]) begin
				s_d.cfg[ch].internal_request_select = wd[CTRL_ISEL_BIT];
				s_d.cfg[ch].high_prio = wd[CTRL_PRIO_BIT];
				s_d.cfg[ch].sync_mode_field = sync_mode_type'(wd[CTRL_SYNC_LO +: 2]);
				s_d.cfg[ch].int_enable = wd[CTRL_INT_BIT];
				s_d.cfg[ch].stop_at_count_zero = wd[CTRL_STOP_BIT];
				s_d.cfg[ch].word_size = wd[CTRL_WORD_BIT];
				if (wd[CTRL_GUARD_BIT]) begin
					s_d.cfg[ch].channel_arm = wd[CTRL_ARM_BIT];
				end
			end else if (a < PRIO_OFS && a[2:0] == COUNT_OFS[2:0]) begin
				s_d.transfer_counter[ch] = wd[15:0];
			end else if (a == PRIO_OFS) begin
				s_d.module_a_priority = wd[PRIO_A_BIT];
				s_d.module_b_priority = wd[PRIO_B_BIT];
				s_d.module_a_internal_source = wd[SRC_A_BIT];
				s_d.module_b_internal_source = wd[SRC_B_BIT];
			end else if (a == HALT_OFS) begin
				if (wd[HALT_MASK_SHIFT + HALT_NMI_BIT]) begin
					s_d.halt_on_nmi_flag = wd[HALT_NMI_BIT];
				end
				if (wd[HALT_MASK_SHIFT + HALT_A_BIT]) begin
					s_d.halt_module_a = wd[HALT_A_BIT];
				end
				if (wd[HALT_MASK_SHIFT + HALT_B_BIT]) begin
					s_d.halt_module_b = wd[HALT_B_BIT];
				end
			end
		end
		if (hw_nmi) begin
			s_d.halt_on_nmi_flag = 1'b1;
		end
		// Transfer engine
		case (s_q.st)
			XF_IDLE: begin
				if (any_grant) begin
					s_d.cur = grant;
					s_d.cnt = 4'(MIN_LAT_CYCLES - 2);
					s_d.st = XF_LAT;
				end
			end
			XF_LAT: begin
				// Synchronize-and-prioritize delay before the bus cycle
				if (s_q.cnt != 4'h0) begin
					s_d.cnt = s_q.cnt - 4'h1;
				end else if (!eligible[s_q.cur]) begin
					s_d.st = XF_IDLE;
				end else begin
					s_d.st = XF_RUN;
					s_d.cnt = run_len;
					s_d.xfer.busy = 1'b1;
					s_d.xfer.chan = s_q.cur;
					s_d.xfer.word = s_q.cfg[s_q.cur].word_size;
					s_d.xfer.mode = s_q.cfg[s_q.cur].sync_mode_field;
				end
			end
			XF_RUN: begin
				if (s_q.cnt != 4'h0) begin
					s_d.cnt = s_q.cnt - 4'h1;
				end else begin
					s_d.st = XF_IDLE;
					s_d.xfer.busy = 1'b0;
					s_d.xfer.done = 1'b1;
					s_d.pending[s_q.cur] = 1'b0;
					nc = s_q.transfer_counter[s_q.cur] - 16'h0001;
					s_d.transfer_counter[s_q.cur] = nc;
					// Rotation moves away from the served channel and module
					s_d.rot_in[s_q.cur[1]] = ~s_q.cur[0];
					s_d.rot_mod = ~s_q.cur[1];
					if (nc == 16'h0000) begin
						if (s_q.cfg[s_q.cur].stop_at_count_zero
							|| s_q.cfg[s_q.cur].sync_mode_field == SYNC_NONE) begin
							s_d.cfg[s_q.cur].channel_arm = 1'b0;
						end
						if (s_q.cfg[s_q.cur].stop_at_count_zero
							&& s_q.cfg[s_q.cur].int_enable) begin
							s_d.tc_irq[s_q.cur] = 1'b1;
						end
					end
				end
			end
			default: begin
				s_d.st = XF_IDLE;
			end
		endcase
		// A request edge in the completing cycle wins over its clear
		s_d.pending = s_d.pending | new_req;
		// APB answer: ready in the access cycle, read data fetched in setup
		s_d.rsp.pready = apb_req.psel && !apb_req.penable;
		s_d.rsp.pslverr = apb_req.psel && !apb_req.penable && (a[1:0] != 2'b00
			|| a > NMI_OFS);
		if (rd) begin
			if (a < PRIO_OFS && a[2:0] == CTRL_OFS[2:0]) begin
				s_d.rsp.prdata = {23'h0, 1'b0, s_q.cfg[ch].channel_arm,
					s_q.cfg[ch].word_size, s_q.cfg[ch].stop_at_count_zero,
					s_q.cfg[ch].int_enable, s_q.cfg[ch].sync_mode_field,
					s_q.cfg[ch].high_prio, s_q.cfg[ch].internal_request_select};
			end else if (a < PRIO_OFS && a[2:0] == COUNT_OFS[2:0]) begin
				s_d.rsp.prdata = {16'h0, s_q.transfer_counter[ch]};
			end else if (a == PRIO_OFS) begin
				s_d.rsp.prdata = {28'h0, s_q.module_b_internal_source,
					s_q.module_a_internal_source, s_q.module_b_priority,
					s_q.module_a_priority};
			end else if (a == HALT_OFS) begin
				s_d.rsp.prdata = {29'h0, s_q.halt_module_b, s_q.halt_module_a,
					s_q.halt_on_nmi_flag};
			end else if (a == NMI_OFS) begin
				s_d.rsp.prdata = {28'h0, s_q.pending};
			end else begin
				s_d.rsp.prdata = 32'h0;
			end
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign apb_rsp = s_q.rsp;
	assign tc_irq = s_q.tc_irq;
	assign xfer = s_q.xfer;
endmodule // dma_channel_control
`default_nettype wire

// ===== dma_ctl_pkg.sv
// Package for the two-module, four-channel DMA channel control block.
// Assumes a 32-bit APB master and a 10 MHz core clock.
package dma_ctl_pkg;
	localparam int NUM_CH = 4;
	localparam int CLK_MHZ = 10;
	// Latency and transfer pacing
	localparam int MIN_LAT_CYCLES = 4;
	localparam int XFER_CYCLES = 8;
	localparam int DEST_IDLE_CYCLES = 2;
	// Register byte offsets: channel n control at 0x00+8n, count at 0x04+8n
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] COUNT_OFS = 8'h04;
	localparam logic [7:0] CH_STRIDE = 8'h08;
	localparam logic [7:0] PRIO_OFS = 8'h20;
	localparam logic [7:0] HALT_OFS = 8'h24;
	localparam logic [7:0] NMI_OFS = 8'h28;
	// Control register field positions
	localparam int CTRL_ISEL_BIT = 0;
	localparam int CTRL_PRIO_BIT = 1;
	localparam int CTRL_SYNC_LO = 2;
	localparam int CTRL_INT_BIT = 4;
	localparam int CTRL_STOP_BIT = 5;
	localparam int CTRL_WORD_BIT = 6;
	localparam int CTRL_ARM_BIT = 7;
	localparam int CTRL_GUARD_BIT = 8;
	// Priority register field positions
	localparam int PRIO_A_BIT = 0;
	localparam int PRIO_B_BIT = 1;
	localparam int SRC_A_BIT = 2;
	localparam int SRC_B_BIT = 3;
	// Halt register: state bits 0..2, mask bits 4..6
	localparam int HALT_NMI_BIT = 0;
	localparam int HALT_A_BIT = 1;
	localparam int HALT_B_BIT = 2;
	localparam int HALT_MASK_SHIFT = 4;
	// Reset values
	localparam logic [15:0] COUNT_RST = 16'h0000;

	typedef enum logic [1:0] {
		SYNC_NONE = 2'b00,
		SYNC_SRC = 2'b01,
		SYNC_DST = 2'b10,
		SYNC_RSVD = 2'b11
	} sync_mode_type;

	typedef enum logic [1:0] {
		XF_IDLE = 2'b00,
		XF_LAT = 2'b01,
		XF_RUN = 2'b10
	} xfer_state_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} apb_rsp_type;

	typedef struct packed {
		logic internal_request_select;
		logic high_prio;
		sync_mode_type sync_mode_field;
		logic int_enable;
		logic stop_at_count_zero;
		logic word_size;
		logic channel_arm;
	} chan_cfg_type;

	// Per-cycle view of the bus engine for the outside world
	typedef struct packed {
		logic busy;
		logic [1:0] chan;
		logic word;
		sync_mode_type mode;
		logic done;
	} xfer_out_type;
endpackage

// ===== dma_ctl_chk_sva.sv
// Checker for the DMA channel control ports.
// Assumes it is bound onto dma_channel_control.
`timescale 1ns/1ps
`default_nettype none
module dma_ctl_chk (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [3:0] external_request_pin,
	input wire logic hw_nmi,
	input wire logic [3:0] tc_irq,
	input wire dma_ctl_pkg::xfer_out_type xfer
);
	import dma_ctl_pkg::*;
	// Stretch reset by one edge so history functions skip pre-reset values
	logic rst_dly_q;
	always_ff @(posedge core_clk) begin
		rst_dly_q <= sys_rst;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst || rst_dly_q);
	// Bus ownership length and completion pulse
	AST_BUSY_LEN: assert property ($rose(xfer.busy) && xfer.mode != SYNC_DST
		|-> xfer.busy[*8] ##1 !xfer.busy) else $error("busy length wrong");
	AST_BUSY_DST: assert property ($rose(xfer.busy) && xfer.mode == SYNC_DST
		|-> xfer.busy[*8] ##1 xfer.busy[*2] ##1 !xfer.busy) else $error("dest busy wrong");
	AST_DONE_END: assert property ($fell(xfer.busy) |-> xfer.done)
		else $error("done missing");
	AST_DONE_ONE: assert property (xfer.done |=> !xfer.done)
		else $error("done too long");
	// Terminal count interrupt
	AST_IRQ_ONE: assert property (|tc_irq |=> tc_irq == 4'h0)
		else $error("irq too long");
	AST_IRQ_DONE: assert property (|tc_irq |-> xfer.done && $onehot(tc_irq))
		else $error("irq without done");
	// Request latency and NMI suspension
	AST_EXT_LAT: assert property ((|(external_request_pin & ~$past(external_request_pin)))
		&& !xfer.busy && !xfer.done |=> (!xfer.busy)[*4]) else $error("request too fast");
	AST_NMI_HALT: assert property (hw_nmi |-> ##2 (!$rose(xfer.busy))[*8])
		else $error("transfer under nmi");
	COV_DST: cover property ($rose(xfer.busy) && xfer.mode == SYNC_DST);
	COV_IRQ: cover property (|tc_irq);
	COV_NMI: cover property (hw_nmi);
endmodule // dma_ctl_chk
bind dma_channel_control dma_ctl_chk chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
	.external_request_pin(external_request_pin), .hw_nmi(hw_nmi), .tc_irq(tc_irq), .xfer(xfer));
`default_nettype wire

// ===== serial_port_model.sv
// Serial port stand-in: one request pulse per shifted byte.
// Assumes the bench primes a port with its first transmit byte.
`timescale 1ns/1ps
`default_nettype none
module serial_port_model #(
	parameter int SHIFT_CYCLES = 10
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [1:0] prime,
	input wire dma_ctl_pkg::xfer_out_type xfer,
	output logic [1:0] serial_request
);
	import dma_ctl_pkg::*;
	int cnt [2];
	// Shift a byte after priming or a module transfer, then pulse
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < 2; i++) begin
			serial_request[i] <= 1'b0;
			if (sys_rst)
				cnt[i] <= 0;
			else if (prime[i] || (xfer.done && xfer.chan[1] == i[0]))
				cnt[i] <= SHIFT_CYCLES;
			else if (cnt[i] == 1) begin
				cnt[i] <= 0;
				serial_request[i] <= 1'b1;
			end else if (cnt[i] > 1)
				cnt[i] <= cnt[i] - 1;
		end
	end
endmodule // serial_port_model
`default_nettype wire

// ===== dma_channel_control_tb.sv
// Testbench: register rows, then transfer scenarios.
// Assumes the checker binds itself and the serial model paces requests.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control_tb;
	import dma_ctl_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_type;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	apb_req_type req = '0;
	apb_rsp_type rsp;
	logic [3:0] ext = 4'h0;
	logic tmr = 1'b0;
	logic nmi = 1'b0;
	logic iret = 1'b0;
	logic [1:0] prime = 2'b00;
	logic [1:0] ser;
	logic [3:0] irq;
	xfer_out_type xf;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [31:0] rdv;
	logic err;
	xfer_out_type xv;
	row_type rows [11] = '{'{8'h08, 32'hf6, 32'h76, 1'b0}, '{8'h08, 32'h1f6, 32'hf6, 1'b0},
		'{8'h08, 32'h76, 32'hf6, 1'b0}, '{8'h08, 32'h176, 32'h76, 1'b0},
		'{8'h0c, 32'hffff1234, 32'h1234, 1'b0}, '{8'h20, 32'hf, 32'hf, 1'b0},
		'{8'h24, 32'h76, 32'h6, 1'b0}, '{8'h24, 32'h1, 32'h6, 1'b0},
		'{8'h24, 32'h60, 32'h0, 1'b0}, '{8'h2c, 32'h1, 32'h0, 1'b1}, '{8'h02, 32'h1, 32'h0, 1'b1}};
	dma_channel_control dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .apb_req(req),
		.apb_rsp(rsp), .external_request_pin(ext), .timer_request(tmr),
		.serial_request(ser), .hw_nmi(nmi), .irq_return(iret), .tc_irq(irq), .xfer(xf));
	serial_port_model sp_u (.core_clk(core_clk), .sys_rst(sys_rst), .prime(prime),
		.xfer(xf), .serial_request(ser));
	// Clock and hang guard
	initial forever #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge core_clk);
		req.penable <= 1'b1;
		do @(posedge core_clk); while (rsp.pready !== 1'b1);
		rdv = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] q);
		apb(1'b0, a, 32'h0);
		chk(n, q, rdv);
	endtask
	// Count completions and interrupts; keep the first bus owner seen
	task automatic dc(input int n, input int d, input logic [3:0] i);
		int k = 0;
		logic [3:0] s = 4'h0;
		logic got = 1'b0;
		xv = '0;
		repeat (n) begin
			@(posedge core_clk);
			#1;
			if (xf.done === 1'b1) k++;
			if (xf.busy === 1'b1 && !got) begin
				xv = xf;
				got = 1'b1;
			end
			s = s | irq;
		end
		chk("done count", d, k);
		chk("irq", i, s);
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			chk("write error", rows[i].e, err);
			rc("register", rows[i].a, rows[i].q);
			chk("read error", rows[i].e, err);
		end
		$display("test registers done");
		apb(1'b1, 8'h04, 32'h2);
		apb(1'b1, 8'h00, 32'h180);
		dc(60, 2, 4'h0);
		chk("xfer", 32'({1'b1, 2'd0, 1'b0, SYNC_NONE, 1'b0}), 32'(xv));
		rc("ch0 ctrl", 8'h00, 32'h0);
		$display("test burst done");
		apb(1'b1, 8'h0c, 32'h1);
		apb(1'b1, 8'h08, 32'h1f4);
		tmr <= 1'b1;
		prime[0] <= 1'b1;
		@(posedge core_clk);
		tmr <= 1'b0;
		prime[0] <= 1'b0;
		dc(40, 0, 4'h0);
		ext[1] <= 1'b1;
		@(posedge core_clk);
		ext[1] <= 1'b0;
		dc(30, 1, 4'h2);
		chk("xfer", 32'({1'b1, 2'd1, 1'b1, SYNC_SRC, 1'b0}), 32'(xv));
		rc("ch1 ctrl", 8'h08, 32'h74);
		$display("test external done");
		apb(1'b1, 8'h14, 32'h1);
		apb(1'b1, 8'h10, 32'h198);
		ext[2] <= 1'b1;
		@(posedge core_clk);
		ext[2] <= 1'b0;
		dc(40, 1, 4'h0);
		chk("xfer", 32'({1'b1, 2'd2, 1'b0, SYNC_DST, 1'b0}), 32'(xv));
		$display("test destination done");
		apb(1'b1, 8'h20, 32'h8);
		apb(1'b1, 8'h1c, 32'h3);
		apb(1'b1, 8'h18, 32'h1b5);
		ext[3] <= 1'b1;
		tmr <= 1'b1;
		@(posedge core_clk);
		ext[3] <= 1'b0;
		tmr <= 1'b0;
		dc(30, 0, 4'h0);
		prime[1] <= 1'b1;
		@(posedge core_clk);
		prime[1] <= 1'b0;
		dc(200, 3, 4'h8);
		chk("xfer", 32'({1'b1, 2'd3, 1'b0, SYNC_SRC, 1'b0}), 32'(xv));
		$display("test serial done");
		apb(1'b1, 8'h24, 32'h22);
		apb(1'b1, 8'h04, 32'h1);
		apb(1'b1, 8'h00, 32'h180);
		apb(1'b1, 8'h0c, 32'h1);
		apb(1'b1, 8'h08, 32'h182);
		dc(30, 0, 4'h0);
		apb(1'b1, 8'h24, 32'h20);
		dc(40, 2, 4'h0);
		chk("xfer", 32'({1'b1, 2'd1, 1'b0, SYNC_NONE, 1'b0}), 32'(xv));
		nmi <= 1'b1;
		@(posedge core_clk);
		nmi <= 1'b0;
		rc("nmi halt", 8'h24, 32'h1);
		apb(1'b1, 8'h04, 32'h1);
		apb(1'b1, 8'h00, 32'h180);
		dc(20, 0, 4'h0);
		iret <= 1'b1;
		@(posedge core_clk);
		iret <= 1'b0;
		rc("nmi halt", 8'h24, 32'h0);
		dc(20, 1, 4'h0);
		$display("test halt done");
		apb(1'b1, 8'h04, 32'h5);
		apb(1'b1, 8'h00, 32'h180);
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		#1;
		chk("busy", 1'b0, xf.busy);
		rc("ch0 ctrl", 8'h00, 32'h0);
		rc("count", 8'h04, {16'h0, COUNT_RST});
		$display("test reset done");
		stop_test();
	end
endmodule // dma_channel_control_tb
`default_nettype wire
